// File: spa_parked_axis.sv
/*
  Safe parked-axis supervisor with AHB-Lite register slave and fault
  interrupt. Assumes two-channel inputs arrive synchronous to hclk and
  that the slave axes' safe flags come in already decoded from the bus.
*/
// Summary of operation
// - Lock output stage on both channels while parked under safety.
// - Parked safety active only with safety enabled and parked function selected.
// - While parked, drop encoder, speed, acceleration and position supervision.
// - Parked-safe config bit stands in for missing speed information.
// - Single-acknowledge axis asserts both diagnostic outputs when parked-safe set.
// - Slave axis asserts both outputs and forwards safe state on diag bus.
// - PLC master asserts outputs only when all slaves signal safety.
// - Door master also needs all slaves safe plus dual-channel mode selection.
// - Show two-letter parked code on the panel while function active.
// - Fault when acknowledgment signal check disagrees.
// - Fault when dual-channel output stage interlock misbehaves.
// - Fault when cross-channel operating mode validation disagrees.
// - Fault when parameterized and effective thresholds disagree.
`timescale 1ns/1ps
module spa_parked_axis
  import spa_pkg::*;
#(
  parameter int N_SLAVES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic safety_active,
  input wire logic park_select,
  input wire logic [N_SLAVES-1:0] slave_safe,
  input wire logic mode_sel_ch1,
  input wire logic mode_sel_ch2,
  input wire logic mode_ch1_valid,
  input wire logic mode_ch2_valid,
  input wire logic [15:0] thresh_param,
  input wire logic [15:0] thresh_eff,
  input wire logic param_crc_ok,
  input wire logic [1:0] stage_locked_fb,
  input wire logic [1:0] diag_readback,
  output logic [1:0] stage_lock,
  output logic monitor_enable,
  output logic first_diag_output,
  output logic second_diag_output,
  output logic axis_diag_bus,
  output logic [15:0] parked_display_code,
  output logic ack_check_fault,
  output logic safety_param_validation_fault,
  output logic threshold_validation_fault,
  output logic mode_validation_fault,
  output logic stage_interlock_fault,
  output logic irq
);

  spa_state_t state_reg;
  logic [3:0] cfg_reg;
  logic [SPA_IRQ_W-1:0] irq_stat_reg;
  logic [SPA_IRQ_W-1:0] irq_mask_reg;
  logic [SPA_IRQ_W-1:0] events;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [2:0] lag_cnt_reg;
  logic ack_raw;
  logic parked;
  logic parked_safe;
  spa_role_t role;

  function automatic logic [7:0] word_ofs(input logic [31:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction : word_ofs

  assign parked_safe = cfg_reg[SPA_CFG_SAFE_BIT];
  assign role = spa_role_t'(cfg_reg[SPA_CFG_ROLE_LSB +: SPA_CFG_ROLE_W]);
  assign parked = (state_reg == SPA_ST_PARKED);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SPA_ST_RUN;
    end else begin
      case (state_reg)
        SPA_ST_RUN: begin
          if (safety_active && park_select) begin
            state_reg <= SPA_ST_PARKED;
          end
        end
        SPA_ST_PARKED: begin
          if (!(safety_active && park_select)) begin
            state_reg <= SPA_ST_RUN;
          end
        end
        default: state_reg <= SPA_ST_RUN;
      endcase
    end
  end

  // Acknowledgment per role; parked-safe clear forces it off
  always_comb begin
    ack_raw = 1'b0;
    if (parked && parked_safe) begin
      case (role)
        SPA_ROLE_SINGLE: ack_raw = 1'b1;
        SPA_ROLE_SLAVE: ack_raw = 1'b1;
        SPA_ROLE_MASTER_PLC: ack_raw = &slave_safe;
        SPA_ROLE_MASTER_DOOR: ack_raw = (&slave_safe) && mode_sel_ch1 && mode_sel_ch2;
        default: ack_raw = 1'b0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_diag_output <= 1'b0;
      second_diag_output <= 1'b0;
      axis_diag_bus <= 1'b0;
    end else begin
      first_diag_output <= ack_raw;
      second_diag_output <= ack_raw;
      axis_diag_bus <= ack_raw && (role == SPA_ROLE_SLAVE);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_lock <= 2'b11;
      monitor_enable <= 1'b0;
      parked_display_code <= SPA_BLANK_CODE;
    end else begin
      stage_lock <= {2{parked}};
      monitor_enable <= !parked;
      parked_display_code <= parked ? SPA_PARKED_CODE : SPA_BLANK_CODE;
    end
  end

  // Stage feedback may lag the command briefly before it counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lag_cnt_reg <= 3'h0;
    end else if (stage_locked_fb != stage_lock) begin
      if (lag_cnt_reg != 3'(SPA_STAGE_LAG_CYC)) begin
        lag_cnt_reg <= lag_cnt_reg + 3'h1;
      end
    end else begin
      lag_cnt_reg <= 3'h0;
    end
  end

  always_comb begin
    events = '0;
    events[SPA_EV_ACK] = (diag_readback != {second_diag_output, first_diag_output});
    events[SPA_EV_PARAM] = !param_crc_ok;
    events[SPA_EV_THRESH] = (thresh_param != thresh_eff);
    events[SPA_EV_MODE] = (mode_ch1_valid != mode_ch2_valid);
    events[SPA_EV_STAGE] = (lag_cnt_reg == 3'(SPA_STAGE_LAG_CYC));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_check_fault <= 1'b0;
      safety_param_validation_fault <= 1'b0;
      threshold_validation_fault <= 1'b0;
      mode_validation_fault <= 1'b0;
      stage_interlock_fault <= 1'b0;
    end else begin
      ack_check_fault <= events[SPA_EV_ACK];
      safety_param_validation_fault <= events[SPA_EV_PARAM];
      threshold_validation_fault <= events[SPA_EV_THRESH];
      mode_validation_fault <= events[SPA_EV_MODE];
      stage_interlock_fault <= events[SPA_EV_STAGE];
    end
  end

  // AHB-Lite slave: zero wait states, writes land in the data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= word_ofs(haddr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= SPA_CFG_RESET;
      irq_mask_reg <= SPA_IRQ_MASK_RESET;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == SPA_CFG_OFS) begin
        cfg_reg <= hwdata[3:0];
      end
      if (wr_addr_reg == SPA_IRQ_MASK_OFS) begin
        irq_mask_reg <= hwdata[SPA_IRQ_W-1:0];
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= '0;
    end else begin
      if (wr_pend_reg && wr_addr_reg == SPA_IRQ_STAT_OFS) begin
        irq_stat_reg <= (irq_stat_reg & ~hwdata[SPA_IRQ_W-1:0]) | events;
      end else begin
        irq_stat_reg <= irq_stat_reg | events;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (word_ofs(haddr))
        SPA_CFG_OFS: hrdata <= {28'h0000000, cfg_reg};
        SPA_STATUS_OFS: hrdata <= {24'h000000, axis_diag_bus, second_diag_output, first_diag_output,
                                   monitor_enable, stage_lock, 1'b0, parked};
        SPA_IRQ_STAT_OFS: hrdata <= {27'h0, irq_stat_reg};
        SPA_IRQ_MASK_OFS: hrdata <= {27'h0, irq_mask_reg};
        SPA_DISPLAY_OFS: hrdata <= {16'h0000, parked_display_code};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : spa_parked_axis

// File: spa_pkg.sv
/*
  Package for the safe parked-axis supervisor: register map, field
  positions, reset values and enumerations.
  Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
package spa_pkg;
  localparam logic [7:0] SPA_CFG_OFS = 8'h00;
  localparam logic [7:0] SPA_STATUS_OFS = 8'h04;
  localparam logic [7:0] SPA_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] SPA_IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] SPA_DISPLAY_OFS = 8'h10;

  // Configuration register fields
  localparam int SPA_CFG_SAFE_BIT = 0;
  localparam int SPA_CFG_ROLE_LSB = 1;
  localparam int SPA_CFG_ROLE_W = 2;
  localparam logic [3:0] SPA_CFG_RESET = 4'h0;

  // Interrupt status bits, one per fault event
  localparam int SPA_IRQ_W = 5;
  localparam int SPA_EV_ACK = 0;
  localparam int SPA_EV_PARAM = 1;
  localparam int SPA_EV_THRESH = 2;
  localparam int SPA_EV_MODE = 3;
  localparam int SPA_EV_STAGE = 4;
  localparam logic [4:0] SPA_IRQ_MASK_RESET = 5'h00;

  // Two-letter parked code shown on the panel, ASCII
  localparam logic [15:0] SPA_PARKED_CODE = 16'h5041;
  localparam logic [15:0] SPA_BLANK_CODE = 16'h2020;

  // Stage feedback lagging its lock command this many cycles raises the fault
  localparam int SPA_STAGE_LAG_CYC = 4;

  typedef enum logic [1:0] {
    SPA_ROLE_SINGLE,
    SPA_ROLE_SLAVE,
    SPA_ROLE_MASTER_PLC,
    SPA_ROLE_MASTER_DOOR
  } spa_role_t;

  typedef enum {
    SPA_ST_RUN,
    SPA_ST_PARKED
  } spa_state_t;
endpackage : spa_pkg

// File: spa_monitor.sv
/* Port checker for the parked-axis supervisor.
   Bound to spa_parked_axis; one clock domain. */
`timescale 1ns/1ps
module spa_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic safety_active,
  input wire logic park_select,
  input wire logic [15:0] thresh_param,
  input wire logic [15:0] thresh_eff,
  input wire logic [1:0] stage_locked_fb,
  input wire logic [1:0] stage_lock,
  input wire logic monitor_enable,
  input wire logic first_diag_output,
  input wire logic second_diag_output,
  input wire logic [15:0] parked_display_code,
  input wire logic threshold_validation_fault,
  input wire logic stage_interlock_fault
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_park; safety_active && park_select; endsequence
  sequence s_idle; !(safety_active && park_select); endsequence
  // Margin over the lag so the count choice is not pinned
  sequence s_stuck; (stage_locked_fb != stage_lock)[*6]; endsequence
  a_stage_locked: assert property (s_park |-> ##2 stage_lock == 2'b11) else $error("lock off");
  a_monitor_off: assert property (s_park |-> ##2 !monitor_enable) else $error("monitor on");
  a_idle_release: assert property (s_idle |-> ##2 stage_lock == 2'b00 && monitor_enable) else $error("idle");
  a_display_code: assert property (s_park |-> ##2 parked_display_code == 16'h5041) else $error("display");
  a_diag_pair: assert property (first_diag_output == second_diag_output) else $error("diag pair");
  a_diag_idle: assert property (s_idle |-> ##2 !first_diag_output) else $error("diag idle");
  a_thresh_fault: assert property (1'b1 |=> threshold_validation_fault == $past(thresh_param != thresh_eff))
    else $error("thresh");
  a_stage_fault: assert property (s_stuck |=> stage_interlock_fault) else $error("stage");
endmodule : spa_monitor
bind spa_parked_axis spa_monitor u_mon (.*);

// File: spa_far_end.sv
/* Output stage and diagnostic readback seen by the supervisor.
   Stall freezes the stage feedback; bad_echo corrupts readback.
   Assumes the bench drives stall and bad_echo off the clock edge. */
`timescale 1ns/1ps
module spa_far_end (
  input wire logic hclk,
  input wire logic [1:0] stage_lock,
  input wire logic first_diag_output,
  input wire logic second_diag_output,
  input wire logic stall,
  input wire logic bad_echo,
  output logic [1:0] stage_locked_fb,
  output logic [1:0] diag_readback
);
  // Readback echoes the outputs unless a fault is injected
  assign diag_readback = {second_diag_output, first_diag_output ^ bad_echo};
  always_ff @(posedge hclk) begin
    if (!stall) begin
      stage_locked_fb <= stage_lock;
    end
  end
endmodule : spa_far_end

// File: spa_tb.sv
/* Self-checking bench for the parked-axis supervisor.
   Needs spa_pkg, spa_parked_axis, spa_far_end and spa_monitor. */
`timescale 1ns/1ps
module testbench;
  import spa_pkg::*;
  logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, hready, hreadyout, hresp, irq, e;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0, stage_lock, stage_locked_fb, diag_readback;
  logic [2:0] hsize = 3'h2;
  logic safety_active = '0, park_select = '0, mode_sel_ch1 = '0, mode_sel_ch2 = '0, stall = '0, bad_echo = '0;
  logic mode_ch1_valid = '1, mode_ch2_valid = '1, param_crc_ok = '1, monitor_enable, axis_diag_bus;
  logic first_diag_output, second_diag_output, ack_check_fault, safety_param_validation_fault;
  logic threshold_validation_fault, mode_validation_fault, stage_interlock_fault;
  logic [3:0] slave_safe = '0;
  logic [15:0] thresh_param = '0, thresh_eff = '0, parked_display_code;
  logic [7:0] lf = 8'h3D;
  logic [4:0] msk;
  int miscompares = 0;
  int comparisons = 0;
  assign hready = hreadyout;
  spa_parked_axis #(.N_SLAVES(4)) uut (.*);
  spa_far_end far (.*);
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1 && ++n < 50);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1 && ++n < 99);
    rd = hrdata;
    if (n >= 99) begin
      miscompares++;
      complete_run;
    end
  endtask : bus
  task automatic cause(input int k, input logic v);
    case (k)
      0: bad_echo <= v;
      1: param_crc_ok <= !v;
      2: thresh_eff <= v ? {lf, 8'h01} : 16'h0;
      3: mode_ch2_valid <= !v;
      default: begin
        stall <= v;
        safety_active <= v;
        park_select <= v;
      end
    endcase
  endtask : cause
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h0, SPA_CFG_OFS, '0);
    chk("cfg", {28'h0, SPA_CFG_RESET}, rd);
    bus(1'h0, 8'h40, '0);
    chk("unmapped", '0, rd);
    chk("hresp", '0, {31'h0, hresp});
    for (int i = 0; i < 32; i++) begin
      lf = lfsr(lf);
      bus(1'h1, SPA_CFG_OFS, {29'h0, i[2:0]});
      bus(1'h0, SPA_CFG_OFS, '0);
      chk("cfg rd", {29'h0, i[2:0]}, rd);
      slave_safe <= i[3] ? 4'hF : lf[3:0];
      mode_sel_ch1 <= i[4];
      mode_sel_ch2 <= i[4] | lf[5];
      safety_active <= 1'h1;
      park_select <= 1'h1;
      repeat (3) @(posedge hclk);
      e = i[0] && (i[2:1] < 2 || (&slave_safe && (i[2:1] == 2 || (mode_sel_ch1 && mode_sel_ch2))));
      chk("diag", {e, e, e && i[2:1] == 1}, {first_diag_output, second_diag_output, axis_diag_bus});
      chk("park", {3'h6, SPA_PARKED_CODE}, {stage_lock, monitor_enable, parked_display_code});
      bus(1'h0, SPA_STATUS_OFS, '0);
      chk("status", {24'h0, e && i[2:1] == 1, e, e, 5'h0D}, rd);
      bus(1'h0, SPA_DISPLAY_OFS, '0);
      chk("display", {16'h0, SPA_PARKED_CODE}, rd);
      safety_active <= lf[6];
      park_select <= !lf[6];
      repeat (3) @(posedge hclk);
      chk("run", {6'h1, SPA_BLANK_CODE}, {first_diag_output, second_diag_output, axis_diag_bus, stage_lock,
        monitor_enable, parked_display_code});
    end
    for (int k = 0; k < 5; k++) begin
      msk = lf[4:0];
      lf = lfsr(lf);
      bus(1'h1, SPA_IRQ_MASK_OFS, {27'h0, msk});
      bus(1'h0, SPA_IRQ_MASK_OFS, '0);
      chk("mask", {27'h0, msk}, rd);
      cause(k, 1'h1);
      repeat (12) @(posedge hclk);
      chk("fault", 32'h1 << k, {stage_interlock_fault, mode_validation_fault, threshold_validation_fault,
        safety_param_validation_fault, ack_check_fault});
      cause(k, 1'h0);
      repeat (3) @(posedge hclk);
      chk("irq", {31'h0, msk[k]}, {31'h0, irq});
      bus(1'h0, SPA_IRQ_STAT_OFS, '0);
      chk("stat", 32'h1 << k, rd);
      bus(1'h1, SPA_IRQ_STAT_OFS, 32'h1 << k);
      bus(1'h0, SPA_IRQ_STAT_OFS, '0);
      chk("clear", '0, rd | irq);
    end
    complete_run;
  end
endmodule : testbench
